// ### logic/codec_regs_pkg.sv
// Constants, register map and carrier types for the codec page, reset and power register bank.
// Assumes a single 200 MHz control clock; all offsets are byte addresses inside a register page.
package codec_regs_pkg;

    // Control clock rate in MHz, used to turn printed times into cycle counts.
    localparam int unsigned CLK_FREQ_MHZ = 200;

    // Offsets of the registers that carry behaviour in this bank.
    localparam logic [7:0] OFS_PAGE_SELECT     = 8'h00;
    localparam logic [7:0] OFS_SOFT_RESET      = 8'h01;
    localparam logic [7:0] OFS_REF_SLEEP       = 8'h02;
    localparam logic [7:0] OFS_SUPPLY_STATUS   = 8'h03;
    localparam logic [7:0] OFS_DEVICE_STATUS_A = 8'h79;
    localparam logic [7:0] OFS_DEVICE_STATUS_B = 8'h7a;
    localparam logic [7:0] OFS_CHANNEL_ENABLE  = 8'h76;

    // Page that holds this bank.
    localparam logic [7:0] BANK_PAGE = 8'h00;

    // Values after reset.
    localparam logic [7:0] RST_PAGE_SELECT     = 8'h00;
    localparam logic [7:0] RST_REF_SLEEP       = 8'h00;
    localparam logic [7:0] RST_DEVICE_STATUS_A = 8'h00;
    localparam logic [7:0] RST_DEVICE_STATUS_B = 8'h80;

    // Field positions.
    localparam int unsigned SOFT_RESET_BIT    = 0;
    localparam int unsigned REF_SLEEP_MSB     = 5;
    localparam int unsigned OVERRIDE_FLAG_BIT = 7;

    // Plain read/write configuration registers of page 0: offsets and reset values.
    localparam int unsigned NUM_GEN = 15;
    localparam logic [7:0] GEN_OFS [NUM_GEN] = '{
        8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70,
        8'h71, 8'h72, 8'h73, 8'h76, 8'h77, 8'h78, 8'h7e};
    localparam logic [7:0] GEN_RST [NUM_GEN] = '{
        8'hc9, 8'h80, 8'h20, 8'h20, 8'h20, 8'hc9, 8'h80, 8'hc9,
        8'h80, 8'h18, 8'h18, 8'hcc, 8'h00, 8'h00, 8'h00};
    localparam logic [3:0] GEN_NONE = 4'hf;

    // Reference quick-charge times in microseconds and their cycle counts.
    localparam int unsigned QCHG_TIME0_US = 3500;
    localparam int unsigned QCHG_TIME1_US = 10000;
    localparam int unsigned QCHG_TIME2_US = 50000;
    localparam int unsigned QCHG_TIME3_US = 100000;
    localparam int unsigned QCHG0_CYCLES  = QCHG_TIME0_US * CLK_FREQ_MHZ;
    localparam int unsigned QCHG1_CYCLES  = QCHG_TIME1_US * CLK_FREQ_MHZ;
    localparam int unsigned QCHG2_CYCLES  = QCHG_TIME2_US * CLK_FREQ_MHZ;
    localparam int unsigned QCHG3_CYCLES  = QCHG_TIME3_US * CLK_FREQ_MHZ;
    localparam int unsigned QCNT_W        = 25;

    // Reference and sleep configuration fields, bit 5 down to bit 0.
    typedef struct packed {
        logic [1:0] reference_quick_charge_time;
        logic       sleep_exit_reference_en;
        logic       analog_supply_mode;
        logic       io_supply_mode;
        logic       sleep_release_n;
    } ref_sleep_cfg_type;

    // Power control outputs toward the analog blocks.
    typedef struct packed {
        logic sleep_active;
        logic digital_regulator_en;
        logic reference_en;
        logic quick_charge_active;
        logic analog_regulator_bypass;
        logic io_speed_unlimited;
    } power_ctrl_type;

    // Sequencer states.
    typedef enum logic [1:0] {
        PWR_SLEEP,
        PWR_CHARGE,
        PWR_AWAKE
    } power_state_type;

endpackage

// ### logic/codec_page_reset_power_regs.sv
// Page select, software reset and reference/sleep configuration bank of the codec, with the
// page-0 channel, output and status registers. Assumes a control-bus target in front of it
// that delivers single byte writes and reads with a page-relative address, synchronous to core_clk.
//
// Summary of operation
// - An 8-bit page selector picks page 0 to 255 for later accesses.
// - Page selector sits at offset 0x0 and resets to page 0.
// - Writing 1 to the soft reset bit restores all defaults; 0 does nothing.
// - The soft reset bit clears itself and always reads back 0.
// - Reserved reset-control bits read zero; host writes only zeros there.
// - Bits 5-4 choose reference quick-charge: 3.5, 10, 50 or 100 ms.
// - Sleep exit enables digital regulator, plus reference when bit 3 set.
// - Bit 2 bypasses the analog regulator; host sets it only at 1.8V.
// - Bit 1 removes the I/O speed limit; never above 2V I/O.
// - Bit 0 low holds sleep, resets low, high leaves sleep.
// - DAC configs reset to 0xc9 and 0x80, outputs to 0x20.
// - Channel enable at 0x76 resets 0xcc, status b at 0x7a 0x80.
// - Analog supply above 2V forces bypass off and sets a status flag.
`timescale 1ns/1ps

module codec_page_reset_power_regs
    import codec_regs_pkg::*;
#(
    parameter int unsigned QCHG_CYCLES_0 = QCHG0_CYCLES,
    parameter int unsigned QCHG_CYCLES_1 = QCHG1_CYCLES,
    parameter int unsigned QCHG_CYCLES_2 = QCHG2_CYCLES,
    parameter int unsigned QCHG_CYCLES_3 = QCHG3_CYCLES
) (
    // Clock and reset.
    input  wire logic           core_clk,
    input  wire logic           rst_n,
    // Register access from the control-bus target.
    input  wire logic           reg_wr_en,
    input  wire logic           reg_rd_en,
    input  wire logic [7:0]     reg_addr,
    input  wire logic [7:0]     reg_wdata,
    output logic      [7:0]     reg_rdata,
    output logic                reg_rd_valid,
    // Analog monitors and device status sources.
    input  wire logic           analog_supply_high,
    input  wire logic [7:0]     device_status_a_in,
    input  wire logic [7:0]     device_status_b_in,
    // Control outputs.
    output logic      [7:0]     current_page,
    output logic                soft_reset_pulse,
    output logic      [7:0]     channel_enable_value,
    output power_ctrl_type      power_ctrl
);

    // Register state and next values.
    logic [7:0]        page_reg;
    logic [7:0]        page_next;
    ref_sleep_cfg_type cfg_reg;
    ref_sleep_cfg_type cfg_next;
    logic [7:0]        gen_reg [NUM_GEN];
    logic [7:0]        gen_next [NUM_GEN];
    logic [7:0]        sts_a_reg;
    logic [7:0]        sts_a_next;
    logic [7:0]        sts_b_reg;
    logic [7:0]        sts_b_next;
    logic              override_reg;
    logic              override_next;
    logic              soft_reg;
    logic              soft_next;
    logic [7:0]        rdata_reg;
    logic [7:0]        rdata_next;
    logic              rvalid_reg;
    logic              rvalid_next;

    // Power sequencer state.
    power_state_type   state_reg;
    power_state_type   state_next;
    logic [QCNT_W-1:0] cnt_reg;
    logic [QCNT_W-1:0] cnt_next;
    power_ctrl_type    pwr_reg;
    power_ctrl_type    pwr_next;

    // What an access reaches in the selected page. The page selector answers on every page;
    // everything else exists only on page 0, so on other pages every offset but the page selector decodes to nothing.
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_PAGE,
        SEL_SOFT_RESET,
        SEL_REF_SLEEP,
        SEL_SUPPLY_STATUS,
        SEL_STATUS_A,
        SEL_STATUS_B,
        SEL_GENERAL
    } reg_sel_type;

    // Decode helpers.
    logic              in_bank;
    logic [3:0]        acc_idx;
    reg_sel_type       acc_sel;

    // Maps a page-0 offset to its slot among the plain configuration registers.
    function automatic logic [3:0] gen_index(input logic [7:0] ofs);
        logic [3:0] idx;
        idx = GEN_NONE;
        for (int i = 0; i < NUM_GEN; i++) begin
            if (GEN_OFS[i] == ofs) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // Quick-charge length in cycles for a field code.
    function automatic logic [QCNT_W-1:0] charge_cycles(input logic [1:0] code);
        logic [QCNT_W-1:0] n;
        unique case (code)
            2'd0: n = QCNT_W'(QCHG_CYCLES_0);
            2'd1: n = QCNT_W'(QCHG_CYCLES_1);
            2'd2: n = QCNT_W'(QCHG_CYCLES_2);
            2'd3: n = QCNT_W'(QCHG_CYCLES_3);
        endcase
        return n;
    endfunction

    // Decodes one offset; the write and the read path share it, so a register can never be
    // writable at one offset and readable at another.
    function automatic reg_sel_type decode_sel(input logic bank, input logic [7:0] ofs);
        reg_sel_type sel;
        sel = SEL_NONE;
        if (ofs == OFS_PAGE_SELECT) begin
            sel = SEL_PAGE;
        end else if (bank) begin
            if (ofs == OFS_SOFT_RESET) begin
                sel = SEL_SOFT_RESET;
            end else if (ofs == OFS_REF_SLEEP) begin
                sel = SEL_REF_SLEEP;
            end else if (ofs == OFS_SUPPLY_STATUS) begin
                sel = SEL_SUPPLY_STATUS;
            end else if (ofs == OFS_DEVICE_STATUS_A) begin
                sel = SEL_STATUS_A;
            end else if (ofs == OFS_DEVICE_STATUS_B) begin
                sel = SEL_STATUS_B;
            end else if (gen_index(ofs) != GEN_NONE) begin
                sel = SEL_GENERAL;
            end
        end
        return sel;
    endfunction

    // Only the page selector is visible on every page; the rest of the bank lives on page 0.
    assign in_bank = (page_reg == BANK_PAGE);
    assign acc_idx = gen_index(reg_addr);
    assign acc_sel = decode_sel(in_bank, reg_addr);

    // Register write path. Soft reset is applied in the same edge as its write, so the
    // reset bit itself never needs storage and can never read back as 1.
    always_comb begin
        page_next = page_reg;
        cfg_next  = cfg_reg;
        gen_next  = gen_reg;
        soft_next = 1'b0;
        if (reg_wr_en) begin
            unique case (acc_sel)
                SEL_PAGE: begin
                    page_next = reg_wdata;
                end
                SEL_SOFT_RESET: begin
                    // Writing 0 is a no-op; reserved bits are dropped.
                    soft_next = reg_wdata[SOFT_RESET_BIT];
                end
                SEL_REF_SLEEP: begin
                    cfg_next = ref_sleep_cfg_type'(reg_wdata[REF_SLEEP_MSB:0]);
                end
                SEL_GENERAL: begin
                    gen_next[acc_idx] = reg_wdata;
                end
                // Status registers are read-only and unmapped offsets ignore writes.
                SEL_NONE, SEL_SUPPLY_STATUS, SEL_STATUS_A, SEL_STATUS_B: begin
                end
            endcase
        end
        if (soft_next) begin
            page_next = RST_PAGE_SELECT;
            cfg_next  = ref_sleep_cfg_type'(RST_REF_SLEEP[REF_SLEEP_MSB:0]);
            for (int i = 0; i < NUM_GEN; i++) begin
                gen_next[i] = GEN_RST[i];
            end
        end
    end

    // Status capture. The inputs are sampled every cycle, so a read sees a value at most one
    // cycle old; a soft reset shows the reset values for one cycle before sampling resumes.
    always_comb begin
        sts_a_next    = device_status_a_in;
        sts_b_next    = device_status_b_in;
        override_next = analog_supply_high;
        if (soft_next) begin
            sts_a_next = RST_DEVICE_STATUS_A;
            sts_b_next = RST_DEVICE_STATUS_B;
        end
    end

    // Status flip-flops.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sts_a_reg    <= RST_DEVICE_STATUS_A;
            sts_b_reg    <= RST_DEVICE_STATUS_B;
            override_reg <= 1'b0;
        end else begin
            sts_a_reg    <= sts_a_next;
            sts_b_reg    <= sts_b_next;
            override_reg <= override_next;
        end
    end

    // Register read path. Unmapped offsets, and every offset but the page selector on other pages, read as zero.
    always_comb begin
        rdata_next  = 8'h00;
        rvalid_next = reg_rd_en;
        if (reg_rd_en) begin
            unique case (acc_sel)
                SEL_PAGE: begin
                    rdata_next = page_reg;
                end
                SEL_SOFT_RESET: begin
                    rdata_next = 8'h00;
                end
                SEL_REF_SLEEP: begin
                    rdata_next = 8'({cfg_reg});
                end
                SEL_SUPPLY_STATUS: begin
                    rdata_next = 8'({override_reg}) << OVERRIDE_FLAG_BIT;
                end
                SEL_STATUS_A: begin
                    rdata_next = sts_a_reg;
                end
                SEL_STATUS_B: begin
                    rdata_next = sts_b_reg;
                end
                SEL_GENERAL: begin
                    rdata_next = gen_reg[acc_idx];
                end
                SEL_NONE: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    // Read answer flip-flops. Kept apart from the register file so that the answer pulse and
    // its data always move together, whatever the write path does in the same cycle.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // Register file flip-flops. A soft reset arrives here only as next values, so the
    // bank never needs a second reset path that could race the bus.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            page_reg     <= RST_PAGE_SELECT;
            cfg_reg      <= ref_sleep_cfg_type'(RST_REF_SLEEP[REF_SLEEP_MSB:0]);
            soft_reg     <= 1'b0;
            for (int i = 0; i < NUM_GEN; i++) begin
                gen_reg[i] <= GEN_RST[i];
            end
        end else begin
            page_reg     <= page_next;
            cfg_reg      <= cfg_next;
            soft_reg     <= soft_next;
            gen_reg      <= gen_next;
        end
    end

    // Power sequencer. Leaving sleep with the reference requested runs the quick-charge
    // timer first; clearing the sleep release bit returns to sleep at once, even mid-charge,
    // so a charge cut short restarts from the full length on the next exit.
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            PWR_SLEEP: begin
                if (cfg_reg.sleep_release_n) begin
                    if (cfg_reg.sleep_exit_reference_en) begin
                        state_next = PWR_CHARGE;
                        cnt_next   = charge_cycles(cfg_reg.reference_quick_charge_time);
                    end else begin
                        state_next = PWR_AWAKE;
                    end
                end
            end
            PWR_CHARGE: begin
                if (cnt_reg <= QCNT_W'(1)) begin
                    state_next = PWR_AWAKE;
                    cnt_next   = '0;
                end else begin
                    cnt_next = cnt_reg - QCNT_W'(1);
                end
            end
            PWR_AWAKE: begin
                state_next = PWR_AWAKE;
            end
        endcase
        if (!cfg_reg.sleep_release_n) begin
            state_next = PWR_SLEEP;
            cnt_next   = '0;
        end
    end

    // Power outputs; all but the bypass and I/O speed bits are decoded from the next state so they move with it.
    always_comb begin
        pwr_next.sleep_active            = (state_next == PWR_SLEEP);
        pwr_next.digital_regulator_en    = (state_next != PWR_SLEEP);
        pwr_next.reference_en            = (state_next == PWR_CHARGE) ||
                                           ((state_next == PWR_AWAKE) && cfg_reg.sleep_exit_reference_en);
        pwr_next.quick_charge_active     = (state_next == PWR_CHARGE);
        // A high supply must never reach the core unregulated, whatever software asked.
        pwr_next.analog_regulator_bypass = cfg_reg.analog_supply_mode && !analog_supply_high;
        pwr_next.io_speed_unlimited      = cfg_reg.io_supply_mode;
    end

    // Power sequencer flip-flops.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= PWR_SLEEP;
            cnt_reg   <= '0;
            pwr_reg   <= '{sleep_active: 1'b1, default: 1'b0};
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            pwr_reg   <= pwr_next;
        end
    end

    // Outputs, all from flip-flops.
    assign reg_rdata            = rdata_reg;
    assign reg_rd_valid         = rvalid_reg;
    assign current_page         = page_reg;
    assign soft_reset_pulse     = soft_reg;
    assign channel_enable_value = gen_reg[gen_index(OFS_CHANNEL_ENABLE)];
    assign power_ctrl           = pwr_reg;

endmodule

// ### verification/codec_host_model.sv
// Host side of the register bank: a byte strobe master driven from bench tasks.
// Assumes the bank takes a strobe at a rising core_clk edge and answers reads one cycle later.
`timescale 1ns/1ps

module codec_host_model (
    // Clock.
    input  wire logic       core_clk,
    // Register access toward the bank.
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    // Read answer.
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rd_valid
);
    // Idle bus at time zero.
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // One byte write held across exactly one rising edge; lines are scrambled afterwards so stale values never help.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge core_clk);
        reg_addr  = addr;
        reg_wdata = (addr == 8'h01) ? {7'h00, data[0]} : data;
        reg_wr_en = 1'b1;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~reg_wdata;
    endtask

    // One byte read; a missing valid pulse returns unknown so any compare fails.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge core_clk);
        reg_addr  = addr;
        reg_rd_en = 1'b1;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        reg_addr  = ~addr;
        data      = (reg_rd_valid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
endmodule

// ### verification/codec_page_reset_power_regs_sva.sv
// Port checker for the codec page, reset and power register bank.
// Assumes it is bound to the bank and sees only the bank's ports.
`timescale 1ns/1ps

module codec_page_reset_power_regs_sva
    import codec_regs_pkg::*;
(
    // Clock and reset.
    input wire logic           core_clk,
    input wire logic           rst_n,
    // Register access.
    input wire logic           reg_wr_en,
    input wire logic           reg_rd_en,
    input wire logic [7:0]     reg_addr,
    input wire logic [7:0]     reg_wdata,
    input wire logic [7:0]     reg_rdata,
    input wire logic           reg_rd_valid,
    // Monitors and controls.
    input wire logic           analog_supply_high,
    input wire logic [7:0]     device_status_a_in,
    input wire logic [7:0]     device_status_b_in,
    input wire logic [7:0]     current_page,
    input wire logic           soft_reset_pulse,
    input wire logic [7:0]     channel_enable_value,
    input wire power_ctrl_type power_ctrl
);
    // A single clock domain, so clock and reset are stated once.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    read_answer_a: assert property (reg_rd_en |=> reg_rd_valid) else $error("read got no answer");
    read_pulse_a: assert property (!reg_rd_en |=> !reg_rd_valid) else $error("valid without read");
    page_write_a: assert property (reg_wr_en && reg_addr == 8'h00 |=> current_page == $past(reg_wdata))
        else $error("page not taken");
    page_read_a: assert property (reg_rd_en && !reg_wr_en && reg_addr == 8'h00 |=> reg_rdata == $past(current_page))
        else $error("page read wrong");
    soft_reset_a: assert property (reg_wr_en && reg_addr == 8'h01 && reg_wdata[0] && current_page == 8'h00
        |=> soft_reset_pulse && current_page == 8'h00 && channel_enable_value == 8'hcc) else $error("no reset");
    reset_clear_a: assert property (soft_reset_pulse && !(reg_wr_en && reg_addr == 8'h01 && reg_wdata[0])
        |=> !soft_reset_pulse) else $error("reset bit stuck");
    sleep_entry_a: assert property (reg_wr_en && reg_addr == 8'h02 && current_page == 8'h00 && !reg_wdata[0]
        |=> ##1 power_ctrl.sleep_active) else $error("sleep not entered");
    reserved_zero_a: assert property (reg_rd_en && reg_addr == 8'h01 |=> reg_rdata == 8'h00)
        else $error("reset register not zero");
    off_page_a: assert property (current_page != 8'h00 && reg_rd_en && reg_addr != 8'h00 |=> reg_rdata == 8'h00)
        else $error("other page answered");
    chan_write_a: assert property (reg_wr_en && reg_addr == 8'h76 && current_page == 8'h00
        |=> channel_enable_value == $past(reg_wdata)) else $error("channel enable not taken");
    awake_digital_regulator_a: assert property (!power_ctrl.sleep_active |-> power_ctrl.digital_regulator_en)
        else $error("awake without regulator");
    bypass_force_a: assert property (power_ctrl.analog_regulator_bypass |-> !$past(analog_supply_high))
        else $error("bypass with high supply");
endmodule

bind codec_page_reset_power_regs codec_page_reset_power_regs_sva chk_u (.*);

// ### verification/tb_codec_page_reset_power_regs.sv
// Self-checking bench for the codec page, reset and power register bank.
// Assumes shortened quick-charge counts; the host model drives all register strobes.
`timescale 1ns/1ps

`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED t=%0t %s", $time, m); end end

module tb_codec_page_reset_power_regs;
    import codec_regs_pkg::*;
    localparam int unsigned QN [4] = '{5, 7, 9, 11};
    logic           core_clk = 1'b0;
    logic           rst_n;
    logic           reg_wr_en, reg_rd_en, reg_rd_valid, soft_reset_pulse, analog_supply_high;
    logic [7:0]     reg_addr, reg_wdata, reg_rdata, status_a, status_b, current_page, chan_en, rd;
    power_ctrl_type power_ctrl;
    int             fails = 0;
    int             checked = 0;
    int             cycles = 0;
    int             n;

    // 200 MHz control clock.
    always #2.5 core_clk = ~core_clk;

    codec_host_model host_u (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

    codec_page_reset_power_regs #(.QCHG_CYCLES_0(QN[0]), .QCHG_CYCLES_1(QN[1]), .QCHG_CYCLES_2(QN[2]),
        .QCHG_CYCLES_3(QN[3])) dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .analog_supply_high(analog_supply_high), .device_status_a_in(status_a),
        .device_status_b_in(status_b), .current_page(current_page), .soft_reset_pulse(soft_reset_pulse),
        .channel_enable_value(chan_en), .power_ctrl(power_ctrl));

    // Prints the counts and the verdict, then stops.
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under two thousand cycles.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    // Main sequence; the status inputs carry their reset values so reset reads stay predictable.
    initial begin
        rst_n = 1'b0;
        analog_supply_high = 1'b0;
        status_a = 8'h00;
        status_b = 8'h80;
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        `CHK(power_ctrl.sleep_active, 1'b1, "not asleep after reset")
        for (int i = 0; i < NUM_GEN; i++) begin
            host_u.read_reg(GEN_OFS[i], rd);
            `CHK(rd, GEN_RST[i], "summary reset value")
        end
        for (int j = 0; j < 4; j++) begin
            host_u.read_reg(j[7:0], rd);
            `CHK(rd, 8'h00, "control reset value")
        end
        host_u.read_reg(8'h7a, rd);
        `CHK(rd, 8'h80, "status b reset value")
        host_u.write_reg(8'h69, 8'h5a);
        host_u.read_reg(8'h69, rd);
        `CHK(rd, 8'h5a, "write readback")
        status_a = 8'h3c;
        host_u.write_reg(8'h79, 8'hff);
        host_u.read_reg(8'h79, rd);
        `CHK(rd, 8'h3c, "read-only status written")
        host_u.write_reg(8'h00, 8'hff);
        host_u.read_reg(8'h00, rd);
        `CHK(rd, 8'hff, "top page")
        `CHK(current_page, 8'hff, "page output")
        host_u.read_reg(8'h76, rd);
        `CHK(rd, 8'h00, "page 0 register seen on other page")
        host_u.write_reg(8'h00, 8'h00);
        // A zero into the reset bit must leave state alone; a one restores every default.
        host_u.write_reg(8'h76, 8'h33);
        host_u.write_reg(8'h01, 8'h00);
        host_u.read_reg(8'h76, rd);
        `CHK(rd, 8'h33, "zero write reset")
        `CHK(chan_en, 8'h33, "channel enable output")
        host_u.write_reg(8'h01, 8'h01);
        `CHK(soft_reset_pulse, 1'b1, "no reset pulse")
        host_u.read_reg(8'h76, rd);
        `CHK(rd, 8'hcc, "default after reset")
        `CHK(chan_en, 8'hcc, "channel enable default")
        host_u.read_reg(8'h01, rd);
        `CHK(rd, 8'h00, "reset bit not cleared")
        // Each quick-charge code from sleep, with the reference enabled on exit.
        for (int c = 0; c < 4; c++) begin
            host_u.write_reg(8'h02, 8'h00);
            @(negedge core_clk);
            `CHK(power_ctrl.sleep_active, 1'b1, "awake after sleep write")
            host_u.write_reg(8'h02, {2'b00, c[1:0], 4'b1001});
            @(negedge core_clk);
            `CHK(power_ctrl.digital_regulator_en, 1'b1, "regulator off on exit")
            n = 0;
            while (power_ctrl.quick_charge_active === 1'b1 && n < 100) begin
                n++;
                @(negedge core_clk);
            end
            `CHK(n, QN[c], "quick-charge length")
            `CHK(power_ctrl.reference_en, 1'b1, "reference off after charge")
        end
        host_u.write_reg(8'h02, 8'h00);
        host_u.write_reg(8'h02, 8'h01);
        @(negedge core_clk);
        `CHK(power_ctrl.reference_en, 1'b0, "reference on without bit 3")
        `CHK(power_ctrl.digital_regulator_en, 1'b1, "regulator off without bit 3")
        `CHK(power_ctrl.sleep_active, 1'b0, "still asleep after release")
        host_u.write_reg(8'h02, 8'h07);
        @(negedge core_clk);
        `CHK(power_ctrl.analog_regulator_bypass, 1'b1, "no bypass")
        `CHK(power_ctrl.io_speed_unlimited, 1'b1, "speed still limited")
        analog_supply_high = 1'b1;
        repeat (2) @(negedge core_clk);
        `CHK(power_ctrl.analog_regulator_bypass, 1'b0, "bypass kept at high supply")
        host_u.read_reg(8'h03, rd);
        `CHK(rd[7], 1'b1, "override flag missing")
        print_verdict();
    end
endmodule
